// ===== rtl/sbf_map.svh
// Address map, master indices and limits of the system bus fabric.
`ifndef SBF_MAP_SVH
`define SBF_MAP_SVH
`define SBF_REGION_ROM 4'h0
`define SBF_REGION_SRAM 4'h1
`define SBF_REGION_FLASH 4'h2
`define SBF_REGION_APB 4'h6
`define SBF_REGION_MSB 31
`define SBF_REGION_LSB 28
`define SBF_APB_BLK_MSB 11
`define SBF_APB_BLK_LSB 8
`define SBF_APB_BLOCKS 8
`define SBF_ROM_WORDS 1024
`define SBF_SRAM_WORDS 1024
`define SBF_AGE_MAX 4'hF
`define SBF_M_IF 0
`define SBF_M_DA 1
`define SBF_M_CA 2
`define SBF_M_MAC 3
`define SBF_M_SD 4
`define SBF_MASTERS 5
`endif

// ===== rtl/sbf_pkg.sv
// Types shared by the system bus fabric files.
package sbf_pkg;
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sbf_req_s;
  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } sbf_rsp_s;
  typedef struct packed {
    logic [7:0] psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } sbf_apb_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sbf_apb_rsp_s;
  typedef struct packed {
    logic ready;
    logic err;
    logic [31:0] rdata;
  } sbf_flash_rsp_s;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbf_jtag_s;
  typedef enum logic [1:0] {SBF_A_IDLE, SBF_A_SETUP, SBF_A_ACCESS, SBF_A_FLASH} sbf_ahb_state_e;
endpackage

// ===== rtl/sbf_mem.sv
// Single-port SRAM array with registered read data.
`timescale 1ns/100ps
`default_nettype none
module sbf_mem #(
  parameter int WORDS = 1024,
  parameter int AW = $clog2(WORDS)
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_reg [WORDS];
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = rdata_o;
    if (en_i && !we_i) begin
      rdata_next = mem_reg[addr_i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (en_i && we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_next;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sbf_fabric.sv
// System bus fabric: memory controller, AHB arbiter, APB decoder and debug pin capture.
// Contract
// - Memory controller holds ROM and SRAM; every memory port may read both and write SRAM, while ROM writes return an error.
// - Memory controller serves its three ports first come, first served.
// - Instruction fetch port reaches memory and also external flash.
// - Data access port carries loads and stores to memory, apart from fetches.
// - Processor reaches registers over its AHB port and has a debug JTAG port.
// - AHB arbiter takes MAC, host, fetch and processor requests, one owner at a time.
// - Each granted AHB request goes to at most one slave: APB decoder or flash; an unmapped one goes to none and errors.
// - APB decoder selects one of eight register blocks by address.
`timescale 1ns/100ps
`default_nettype none
`include "sbf_map.svh"
module sbf_fabric #(
  parameter int ROM_WORDS = `SBF_ROM_WORDS,
  parameter int SRAM_WORDS = `SBF_SRAM_WORDS
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire sbf_pkg::sbf_req_s [4:0] req_i,
  output sbf_pkg::sbf_rsp_s [4:0] rsp_o,
  output sbf_pkg::sbf_apb_s apb_o,
  input wire sbf_pkg::sbf_apb_rsp_s [7:0] apb_rsp_i,
  output sbf_pkg::sbf_req_s flash_o,
  input wire sbf_pkg::sbf_flash_rsp_s flash_rsp_i,
  input wire sbf_pkg::sbf_jtag_s jtag_pin_i,
  output sbf_pkg::sbf_jtag_s jtag_o,
  input wire logic dbg_tdo_i,
  output logic jtag_tdo_o
);
  import sbf_pkg::*;
  localparam int SAW = $clog2(SRAM_WORDS);

  function automatic logic [3:0] region(input logic [31:0] a);
    return a[`SBF_REGION_MSB:`SBF_REGION_LSB];
  endfunction
  function automatic logic is_mem(input logic [31:0] a);
    return (region(a) == `SBF_REGION_ROM) || (region(a) == `SBF_REGION_SRAM);
  endfunction
  function automatic logic mem_ok(input logic [31:0] a);
    logic [25:0] w;
    w = a[27:2];
    if (region(a) == `SBF_REGION_ROM) begin
      return w < 26'(ROM_WORDS);
    end
    return (region(a) == `SBF_REGION_SRAM) && (w < 26'(SRAM_WORDS));
  endfunction
  function automatic logic [31:0] rom_word(input logic [31:0] a);
    return {~a[17:2], a[17:2]};
  endfunction
  function automatic logic [2:0] apb_blk(input logic [31:0] a);
    return a[`SBF_APB_BLK_LSB+2:`SBF_APB_BLK_LSB];
  endfunction
  function automatic logic apb_ok(input logic [31:0] a);
    return (region(a) == `SBF_REGION_APB) &&
      (a[`SBF_APB_BLK_MSB:`SBF_APB_BLK_LSB] < 4'(`SBF_APB_BLOCKS));
  endfunction

  // Memory controller: per-port waiting age decides the order of service.
  logic [3:0] age_reg [3];
  logic [3:0] age_next [3];
  logic [2:0] mem_cand;
  logic mem_busy_reg, mem_busy_next, mem_gnt;
  logic [1:0] mem_own_reg, mem_own_next, mem_gidx;
  logic mem_err_reg, mem_err_next, mem_rom_reg, mem_rom_next;
  logic [31:0] rom_data_reg, rom_data_next, sram_rdata;
  logic sram_en;
  sbf_req_s mreq;

  always_comb begin
    mem_cand[0] = is_mem(req_i[`SBF_M_IF].addr);
    mem_cand[1] = 1'b1;
    mem_cand[2] = is_mem(req_i[`SBF_M_CA].addr);
    for (int i = 0; i < 3; i++) begin
      mem_cand[i] = mem_cand[i] && req_i[i].valid && !rsp_o[i].done &&
        !(mem_busy_reg && mem_own_reg == 2'(i));
    end
    mem_gnt = 1'b0;
    mem_gidx = 2'd0;
    for (int i = 0; i < 3; i++) begin
      age_next[i] = !mem_cand[i] ? 4'h0 :
        (age_reg[i] == `SBF_AGE_MAX) ? age_reg[i] : age_reg[i] + 4'h1;
      // The oldest waiter wins; on equal age the later index wins.
      if (!mem_busy_reg && mem_cand[i] && (!mem_gnt || age_reg[i] >= age_reg[mem_gidx])) begin
        mem_gnt = 1'b1;
        mem_gidx = 2'(i);
      end
    end
    mreq = req_i[mem_gidx];
    mem_busy_next = mem_gnt;
    mem_own_next = mem_gnt ? mem_gidx : mem_own_reg;
    mem_rom_next = region(mreq.addr) == `SBF_REGION_ROM;
    // The ROM is read-only and out-of-range words do not exist.
    mem_err_next = !mem_ok(mreq.addr) || (mem_rom_next && mreq.we);
    rom_data_next = rom_word(mreq.addr);
    sram_en = mem_gnt && !mem_err_next && !mem_rom_next;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        age_reg[i] <= 4'h0;
      end
      mem_busy_reg <= 1'b0;
      mem_own_reg <= 2'd0;
      mem_err_reg <= 1'b0;
      mem_rom_reg <= 1'b0;
      rom_data_reg <= 32'h0000_0000;
    end else begin
      age_reg <= age_next;
      mem_busy_reg <= mem_busy_next;
      mem_own_reg <= mem_own_next;
      mem_err_reg <= mem_err_next;
      mem_rom_reg <= mem_rom_next;
      rom_data_reg <= rom_data_next;
    end
  end

  sbf_mem #(.WORDS(SRAM_WORDS)) u_sram (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .en_i(sram_en),
    .we_i(mreq.we),
    .addr_i(mreq.addr[SAW+1:2]),
    .wdata_i(mreq.wdata),
    .rdata_o(sram_rdata)
  );

  // AHB arbiter, slave decode and APB decoder.
  sbf_ahb_state_e ahb_state_reg, ahb_state_next;
  logic [2:0] ahb_own_reg, ahb_own_next, ahb_gidx;
  logic [4:0] ahb_want;
  logic ahb_gnt, ahb_bad, ahb_fin;
  sbf_rsp_s ahb_rsp;
  sbf_apb_s apb_next;
  sbf_req_s flash_next, areq;
  sbf_apb_rsp_s sel_rsp;

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ahb_want[i] = req_i[i].valid && !rsp_o[i].done;
    end
    ahb_want[`SBF_M_IF] = ahb_want[`SBF_M_IF] && !is_mem(req_i[`SBF_M_IF].addr);
    ahb_want[`SBF_M_DA] = 1'b0;
    ahb_want[`SBF_M_CA] = ahb_want[`SBF_M_CA] && !is_mem(req_i[`SBF_M_CA].addr);
    ahb_gnt = (ahb_state_reg == SBF_A_IDLE) && (|ahb_want);
    // Fixed order MAC, host, fetch, processor register port.
    ahb_gidx = ahb_want[`SBF_M_MAC] ? 3'(`SBF_M_MAC) : ahb_want[`SBF_M_SD] ? 3'(`SBF_M_SD) :
      ahb_want[`SBF_M_IF] ? 3'(`SBF_M_IF) : 3'(`SBF_M_CA);
    areq = req_i[ahb_gidx];
    ahb_bad = !apb_ok(areq.addr) && (region(areq.addr) != `SBF_REGION_FLASH);
    sel_rsp = apb_rsp_i[apb_blk(apb_o.paddr)];
    ahb_state_next = ahb_state_reg;
    ahb_own_next = ahb_own_reg;
    apb_next = apb_o;
    flash_next = flash_o;
    ahb_fin = 1'b0;
    ahb_rsp = '0;
    case (ahb_state_reg)
      SBF_A_IDLE: begin
        if (ahb_gnt) begin
          ahb_own_next = ahb_gidx;
          if (ahb_bad) begin
            ahb_fin = 1'b1;
            ahb_rsp.err = 1'b1;
          end else if (apb_ok(areq.addr)) begin
            apb_next.psel = 8'h01 << apb_blk(areq.addr);
            apb_next.penable = 1'b0;
            apb_next.pwrite = areq.we;
            apb_next.paddr = areq.addr;
            apb_next.pwdata = areq.wdata;
            ahb_state_next = SBF_A_SETUP;
          end else begin
            flash_next = areq;
            ahb_state_next = SBF_A_FLASH;
          end
        end
      end
      SBF_A_SETUP: begin
        apb_next.penable = 1'b1;
        ahb_state_next = SBF_A_ACCESS;
      end
      SBF_A_ACCESS: begin
        if (sel_rsp.pready) begin
          apb_next = '0;
          ahb_fin = 1'b1;
          ahb_rsp.err = sel_rsp.pslverr;
          ahb_rsp.rdata = sel_rsp.prdata;
          ahb_state_next = SBF_A_IDLE;
        end
      end
      SBF_A_FLASH: begin
        if (flash_rsp_i.ready) begin
          flash_next = '0;
          ahb_fin = 1'b1;
          ahb_rsp.err = flash_rsp_i.err;
          ahb_rsp.rdata = flash_rsp_i.rdata;
          ahb_state_next = SBF_A_IDLE;
        end
      end
      default: begin
        apb_next = '0;
        flash_next = '0;
        ahb_state_next = SBF_A_IDLE;
      end
    endcase
    ahb_rsp.done = ahb_fin;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ahb_state_reg <= SBF_A_IDLE;
      ahb_own_reg <= 3'd0;
      apb_o <= '0;
      flash_o <= '0;
    end else begin
      ahb_state_reg <= ahb_state_next;
      ahb_own_reg <= ahb_own_next;
      apb_o <= apb_next;
      flash_o <= flash_next;
    end
  end

  // Response registers collect completions from both paths.
  sbf_rsp_s [4:0] rsp_next;
  logic [2:0] fin_idx;

  always_comb begin
    rsp_next = '0;
    fin_idx = (ahb_state_reg == SBF_A_IDLE) ? ahb_gidx : ahb_own_reg;
    if (mem_busy_reg) begin
      rsp_next[mem_own_reg].done = 1'b1;
      rsp_next[mem_own_reg].err = mem_err_reg;
      rsp_next[mem_own_reg].rdata = mem_err_reg ? 32'h0000_0000 :
        mem_rom_reg ? rom_data_reg : sram_rdata;
    end
    if (ahb_fin) begin
      rsp_next[fin_idx] = ahb_rsp;
    end
  end

  // JTAG pins are captured through two flip-flops before use; TDO passes through one.
  sbf_jtag_s jtag_s1_reg, jtag_s1_next, jtag_next;
  logic tdo_next;

  always_comb begin
    jtag_s1_next = jtag_pin_i;
    jtag_next = jtag_s1_reg;
    tdo_next = dbg_tdo_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_o <= '0;
      jtag_s1_reg <= '0;
      jtag_o <= '0;
      jtag_tdo_o <= 1'b0;
    end else begin
      rsp_o <= rsp_next;
      jtag_s1_reg <= jtag_s1_next;
      jtag_o <= jtag_next;
      jtag_tdo_o <= tdo_next;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_rom_read;
    logic [31:0] a;
    (mem_gnt && mem_gidx == 2'd1 && !req_i[1].we && region(req_i[1].addr) == `SBF_REGION_ROM
      && mem_ok(req_i[1].addr), a = req_i[1].addr) |-> ##2 rsp_o[1].done && !rsp_o[1].err
      && rsp_o[1].rdata == rom_word(a);
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("ROM read data wrong");
  property p_fcfs;
    mem_gnt |-> (!mem_cand[0] || age_reg[0] <= age_reg[mem_gidx]) &&
      (!mem_cand[1] || age_reg[1] <= age_reg[mem_gidx]) &&
      (!mem_cand[2] || age_reg[2] <= age_reg[mem_gidx]);
  endproperty
  a_fcfs: assert property (p_fcfs) else $error("Memory grant skipped an older request");
  property p_fetch_flash;
    req_i[0].valid && region(req_i[0].addr) == `SBF_REGION_FLASH && !rsp_o[0].done
      && !req_i[3].valid && !req_i[4].valid |-> ##[0:12] flash_o.valid;
  endproperty
  a_fetch_flash: assert property (p_fetch_flash) else $error("Fetch never reached flash");
  property p_data_mem;
    rsp_o[1].done |-> $past(mem_busy_reg) && $past(mem_own_reg) == 2'd1;
  endproperty
  a_data_mem: assert property (p_data_mem) else $error("Data port answered off memory");
  property p_jtag;
    $past(rst_n_i) && $past(rst_n_i, 2) |-> jtag_o == $past(jtag_pin_i, 2);
  endproperty
  a_jtag: assert property (p_jtag) else $error("Debug pins not passed after two stages");
  property p_one_slave;
    $onehot0(apb_o.psel) && !((|apb_o.psel) && flash_o.valid);
  endproperty
  a_one_slave: assert property (p_one_slave) else $error("More than one slave selected");
  property p_decode;
    (flash_o.valid |-> region(flash_o.addr) == `SBF_REGION_FLASH) and
      ((|apb_o.psel) |-> apb_ok(apb_o.paddr));
  endproperty
  a_decode: assert property (p_decode) else $error("Slave selected for wrong address");
  property p_apb_sel;
    $rose(|apb_o.psel) |-> apb_o.psel == (8'h01 << apb_blk(apb_o.paddr)) && !apb_o.penable
      ##1 apb_o.penable && $stable(apb_o.psel);
  endproperty
  a_apb_sel: assert property (p_apb_sel) else $error("APB select or phase wrong");
  property p_tie;
    ahb_state_reg == SBF_A_IDLE && ahb_want[3] && ahb_want[2] |=> ahb_own_reg == 3'd3;
  endproperty
  a_tie: assert property (p_tie) else $error("Processor won a tie");
  property p_unmapped;
    ahb_gnt && ahb_gidx == 3'd3 && ahb_bad |=> rsp_o[3].done && rsp_o[3].err
      && ahb_state_reg == SBF_A_IDLE;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not errored");
  c_mem_tie: cover property (mem_gnt && mem_cand[0] && mem_cand[1] && mem_cand[2]);
  c_flash: cover property (ahb_state_reg == SBF_A_FLASH && flash_rsp_i.ready);
  c_apb_err: cover property (ahb_state_reg == SBF_A_ACCESS && sel_rsp.pready && sel_rsp.pslverr);
endmodule
`default_nettype wire

// ===== tb/sbf_far_model.sv
// Far-side model of the eight register blocks and the flash controller.
`timescale 1ns/100ps
`default_nettype none
module sbf_far_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire sbf_pkg::sbf_apb_s apb_i,
  output sbf_pkg::sbf_apb_rsp_s [7:0] apb_rsp_o,
  input wire sbf_pkg::sbf_req_s flash_i,
  output sbf_pkg::sbf_flash_rsp_s flash_rsp_o
);
  import sbf_pkg::*;
  logic [1:0] wait_reg;
  logic [31:0] junk_reg;
  logic go;
  logic ack;
  logic rdy;
  assign go = !slow_i || wait_reg == 2'h3;
  // Slaves answer at once or after a stall; released data lines change every cycle.
  always_comb begin
    ack = 1'b0;
    for (int k = 0; k < 8; k++) begin
      rdy = apb_i.psel[k] & apb_i.penable & go;
      apb_rsp_o[k].pready = rdy;
      apb_rsp_o[k].pslverr = rdy & (apb_i.paddr[7:0] == 8'hFC);
      apb_rsp_o[k].prdata = rdy ? {8'hB0, 5'h00, 3'(k), apb_i.paddr[15:0]} : junk_reg;
      ack = ack | rdy;
    end
    flash_rsp_o.ready = flash_i.valid & go;
    flash_rsp_o.err = flash_rsp_o.ready & (flash_i.addr[7:0] == 8'hFC);
    flash_rsp_o.rdata = flash_rsp_o.ready ? ~flash_i.addr : junk_reg;
    ack = ack | flash_rsp_o.ready;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 2'h0;
      junk_reg <= 32'h5A5A5A5A;
    end else begin
      junk_reg <= ~junk_reg;
      if (ack || !(apb_i.penable || flash_i.valid)) begin
        wait_reg <= 2'h0;
      end else if (wait_reg != 2'h3) begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/system_bus_fabric_tb.sv
// Self-checking testbench of the system bus fabric.
`timescale 1ns/100ps
`default_nettype none
module system_bus_fabric_tb;
  import sbf_pkg::*;
  typedef struct {
    int m;
    logic we;
    logic [31:0] a;
    logic [31:0] wd;
    logic er;
    logic [31:0] rd;
  } sbf_row_s;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slow = 1'b0;
  sbf_req_s [4:0] req_i = '0;
  sbf_rsp_s [4:0] rsp_o;
  sbf_apb_s apb_o;
  sbf_apb_rsp_s [7:0] apb_rsp_i;
  sbf_req_s flash_o;
  sbf_flash_rsp_s flash_rsp_i;
  sbf_jtag_s jtag_pin_i = '0;
  sbf_jtag_s jtag_o;
  logic dbg_tdo_i = 1'b0;
  logic jtag_tdo_o;
  logic [7:0] seen_psel = '0;
  int both_cnt = 0;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] rdv [5];
  logic erv [5];
  time tv [5];
  sbf_row_s rows [18] = '{
    '{1, 1'b1, 32'h10000010, 32'hCAFE0001, 1'b0, 32'h00000000},
    '{1, 1'b0, 32'h10000010, 32'h00000000, 1'b0, 32'hCAFE0001},
    '{0, 1'b0, 32'h00000040, 32'h00000000, 1'b0, 32'hFFEF0010},
    '{2, 1'b0, 32'h00000040, 32'h00000000, 1'b0, 32'hFFEF0010},
    '{1, 1'b0, 32'h00000040, 32'h00000000, 1'b0, 32'hFFEF0010},
    '{1, 1'b1, 32'h00000040, 32'h00000001, 1'b1, 32'h00000000},
    '{0, 1'b0, 32'h10001000, 32'h00000000, 1'b1, 32'h00000000},
    '{2, 1'b1, 32'h10000FFC, 32'h12345678, 1'b0, 32'h00000000},
    '{0, 1'b0, 32'h10000FFC, 32'h00000000, 1'b0, 32'h12345678},
    '{0, 1'b0, 32'h20000100, 32'h00000000, 1'b0, 32'hDFFFFEFF},
    '{1, 1'b0, 32'h20000100, 32'h00000000, 1'b1, 32'h00000000},
    '{3, 1'b0, 32'h10000010, 32'h00000000, 1'b1, 32'h00000000},
    '{4, 1'b0, 32'h60000004, 32'h00000000, 1'b0, 32'hB0000004},
    '{2, 1'b0, 32'h60000708, 32'h00000000, 1'b0, 32'hB0070708},
    '{4, 1'b0, 32'h60000800, 32'h00000000, 1'b1, 32'h00000000},
    '{3, 1'b0, 32'h30000000, 32'h00000000, 1'b1, 32'h00000000},
    '{3, 1'b1, 32'h600002FC, 32'h00000009, 1'b1, 32'h00000000},
    '{3, 1'b0, 32'h200002FC, 32'h00000000, 1'b1, 32'h00000000}
  };
  sbf_fabric DUT (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(req_i),
    .rsp_o(rsp_o),
    .apb_o(apb_o),
    .apb_rsp_i(apb_rsp_i),
    .flash_o(flash_o),
    .flash_rsp_i(flash_rsp_i),
    .jtag_pin_i(jtag_pin_i),
    .jtag_o(jtag_o),
    .dbg_tdo_i(dbg_tdo_i),
    .jtag_tdo_o(jtag_tdo_o)
  );
  sbf_far_model far (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .slow_i(slow),
    .apb_i(apb_o),
    .apb_rsp_o(apb_rsp_i),
    .flash_i(flash_o),
    .flash_rsp_o(flash_rsp_i)
  );
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (apb_o.penable === 1'b1) begin
      seen_psel <= apb_o.psel;
    end
    if (apb_o.psel != 8'h00 && flash_o.valid === 1'b1) begin
      both_cnt <= both_cnt + 1;
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Holds a request until its done pulse, then drops it at the edge ending that cycle.
  task automatic do_req(input int m, input logic we, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    req_i[m] = '{1'b1, we, a, wd};
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (rsp_o[m].done !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk("done_wait", 32'h0, 32'h1);
    end
    rdv[m] = rsp_o[m].rdata;
    erv[m] = rsp_o[m].err;
    tv[m] = $time;
    @(posedge clk_sys_i);
    #1;
    req_i[m] = '0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("reset_out", 32'({rsp_o != '0, apb_o != '0, flash_o != '0}), 32'h0);
    rst_n_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      slow = p[0];
      foreach (rows[i]) begin
        do_req(rows[i].m, rows[i].we, rows[i].a, rows[i].wd);
        chk("row_err", 32'(erv[rows[i].m]), 32'(rows[i].er));
        if (!rows[i].er && !rows[i].we) begin
          chk("row_rdata", rdv[rows[i].m], rows[i].rd);
        end
      end
    end
    for (int k = 0; k < 8; k++) begin
      do_req(3, 1'b0, {20'h60000, 1'b0, 3'(k), 8'h10}, 32'h0);
      chk("blk_psel", 32'(seen_psel), 32'(8'h01 << k));
      chk("blk_rdata", rdv[3], {8'hB0, 5'h00, 3'(k), 16'(k * 256 + 16)});
    end
    fork
      do_req(1, 1'b0, 32'h10000010, 32'h0);
      begin
        @(posedge clk_sys_i);
        #1;
        do_req(0, 1'b0, 32'h10000010, 32'h0);
      end
      begin
        repeat (2) @(posedge clk_sys_i);
        #1;
        do_req(2, 1'b0, 32'h10000010, 32'h0);
      end
    join
    chk("fcfs_order", 32'(tv[1] < tv[0] && tv[0] < tv[2]), 32'h1);
    fork
      do_req(2, 1'b0, 32'h60000304, 32'h0);
      do_req(4, 1'b0, 32'h60000204, 32'h0);
      do_req(3, 1'b0, 32'h60000104, 32'h0);
    join
    chk("tie_order", 32'(tv[3] < tv[4] && tv[4] < tv[2]), 32'h1);
    chk("one_slave", 32'(both_cnt), 32'h0);
    jtag_pin_i = 3'b101;
    dbg_tdo_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("tdo_copy", 32'(jtag_tdo_o), 32'h1);
    chk("jtag_early", 32'(jtag_o), 32'h0);
    @(posedge clk_sys_i);
    #1;
    chk("jtag_sync", 32'(jtag_o), 32'h5);
    slow = 1'b1;
    req_i[3] = '{1'b1, 1'b0, 32'h60000104, 32'h0};
    repeat (2) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b0;
    req_i[3] = '0;
    #1;
    chk("midrun_reset", 32'({rsp_o != '0, apb_o != '0, flash_o != '0}), 32'h0);
    repeat (3) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    do_req(0, 1'b0, 32'h20000100, 32'h0);
    chk("after_reset", rdv[0], 32'hDFFFFEFF);
    close_out();
  end
endmodule
`default_nettype wire
